// [cog_clock_out.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] crosspoint routes ref or any PLL anywhere
// [RL2] A and B divider chosen by select level
// [RL3] C divider single setting, select ignored
// [RL4] enable mode low tristates all outputs
// [RL5] shutdown low tristates and stops everything
// [RL6] PLLs relock after leaving shutdown
// [RL7] suspend low disables programmed outputs and PLLs
// [RL8] suspended PLL feeding an unsuspended output is flagged
// [RL9] suspended PLL stops, suspended output tristates
// [RL10] inverted PLL phase selectable per output
// [RL11] general input has exactly one function
// [RL12] divider change from select is glitch free
// [RL13] PLL rate is reference times P over 256 Q
// [RL14] stored settings applied before outputs enable
module cog_clock_out
    import cog_pkg::*;
#(
    parameter int unsigned LOCK_CYC = LOCK_CYCLES
)(
    input  wire logic              i_clk_sys,
    input  wire logic              i_arst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output var  logic [DATA_W-1:0] o_rdata,
    input  wire logic              i_frequency_select_input,
    output var  logic              o_clock_output_a,
    output var  logic              o_clock_output_a_oe,
    output var  logic              o_clock_output_b,
    output var  logic              o_clock_output_b_oe,
    output var  logic              o_clock_output_c,
    output var  logic              o_clock_output_c_oe
);
    cog_cfg_s          cfg_reg;
    logic              pin_s1_reg;
    logic              pin_s2_reg;
    logic              loaded_reg;
    logic [2:0]        oe_reg;
    logic [2:0]        oe_next;
    logic [2:0]        clk_out;
    logic              pin_low;
    logic              shutdown;
    logic              suspend_low;
    logic              oe_low;
    logic              fs_level;
    logic [2:0]        pll_off;
    logic [2:0]        pll_tick;
    logic [2:0]        pll_locked;
    logic [3:0]        src_tick;
    logic [2:0]        out_tick;
    logic [2:0][DIV_W-1:0] div_val;
    logic              conflict;
    logic [DATA_W-1:0] rd_value;
    logic [DATA_W-1:0] status_word;

    // ------------------------------------------------------------
    // general-purpose input and its single function
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            loaded_reg <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= i_frequency_select_input;
            pin_s2_reg <= pin_s1_reg;
            loaded_reg <= 1'b1; // [RL14]
        end
    end

    assign pin_low     = ~pin_s2_reg;
    assign fs_level    = (cfg_reg.gp_mode == GP_FS) & pin_s2_reg;        // [RL11]
    assign suspend_low = (cfg_reg.gp_mode == GP_SUSPEND) & pin_low;      // [RL11]
    assign oe_low      = (cfg_reg.gp_mode == GP_OE) & pin_low;           // [RL11]
    assign shutdown    = (cfg_reg.gp_mode == GP_SHUTDOWN) & pin_low;     // [RL11]

    // ------------------------------------------------------------
    // settings store, loaded with the power-up image at reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cfg_reg <= CFG_RESET; // [RL14]
        else if (i_wr)
        begin
            unique case (i_addr)
                ADDR_CTRL:
                    cfg_reg.gp_mode <= cog_gpmode_e'(i_wdata[1:0]);
                ADDR_ROUTE:
                begin
                    cfg_reg.sel <= i_wdata[5:0];
                    cfg_reg.inv <= i_wdata[ROUTE_INV_LSB +: 3];
                end
                ADDR_DIV_A:
                begin
                    cfg_reg.div_a0 <= i_wdata[DIV_W-1:0];
                    cfg_reg.div_a1 <= i_wdata[DIV_SET1_LSB +: DIV_W];
                end
                ADDR_DIV_B:
                begin
                    cfg_reg.div_b0 <= i_wdata[DIV_W-1:0];
                    cfg_reg.div_b1 <= i_wdata[DIV_SET1_LSB +: DIV_W];
                end
                ADDR_DIV_C:
                    cfg_reg.div_c <= i_wdata[DIV_W-1:0];
                ADDR_SUSP:
                begin
                    cfg_reg.out_susp <= i_wdata[2:0];
                    cfg_reg.pll_susp <= i_wdata[SUSP_PLL_LSB +: 3];
                end
                ADDR_PLL0, ADDR_PLL0 + 4'h1, ADDR_PLL0 + 4'h2:
                begin
                    cfg_reg.q[i_addr - ADDR_PLL0] <= i_wdata[Q_W-1:0];
                    cfg_reg.p[i_addr - ADDR_PLL0] <= i_wdata[PLL_P_LSB +: P_W];
                end
                default:
                    cfg_reg <= cfg_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // PLL rate models with lock timers
    // ------------------------------------------------------------
    for (genvar g = 0; g < 3; g++)
    begin : g_pll
        logic [ACC_W-1:0]  acc_reg;
        logic [LOCK_W-1:0] lock_reg;
        logic [ACC_W-1:0]  thr;
        logic [ACC_W-1:0]  sum;
        logic              hit;

        assign pll_off[g]    = shutdown | (suspend_low & cfg_reg.pll_susp[g]); // [RL5] [RL9]
        assign thr           = {4'h0, cfg_reg.q[g], 8'h00};
        assign sum           = acc_reg + {9'h000, cfg_reg.p[g]};
        assign hit           = sum >= thr;
        assign pll_locked[g] = (lock_reg == LOCK_W'(LOCK_CYC));
        assign pll_tick[g]   = ~pll_off[g] & pll_locked[g] & hit; // [RL13]

        always_ff @(posedge i_clk_sys or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                acc_reg  <= '0;
                lock_reg <= '0;
            end
            else if (pll_off[g])
            begin
                acc_reg  <= '0;
                lock_reg <= '0; // [RL6]
            end
            else
            begin
                acc_reg <= hit ? sum - thr : sum; // [RL13]
                if (!pll_locked[g])
                    lock_reg <= lock_reg + LOCK_W'(1); // [RL6]
            end
        end
    end

    // ------------------------------------------------------------
    // crosspoint, post dividers and output enables
    // ------------------------------------------------------------
    assign src_tick   = {pll_tick, ~shutdown};
    assign div_val[0] = fs_level ? cfg_reg.div_a1 : cfg_reg.div_a0; // [RL2]
    assign div_val[1] = fs_level ? cfg_reg.div_b1 : cfg_reg.div_b0; // [RL2]
    assign div_val[2] = cfg_reg.div_c;                              // [RL3]

    for (genvar k = 0; k < 3; k++)
    begin : g_out
        assign out_tick[k] = src_tick[cfg_reg.sel[k]]; // [RL1]
        assign oe_next[k]  = loaded_reg & ~shutdown & ~oe_low                   // [RL4] [RL5]
                             & ~(suspend_low & cfg_reg.out_susp[k]);            // [RL7] [RL9]

        cog_post_div u_div (
            .i_clk_sys (i_clk_sys),
            .i_arst_n  (i_arst_n),
            .i_clear   (shutdown),
            .i_tick    (out_tick[k]),
            .i_div     (div_val[k]),
            .i_inv     (cfg_reg.inv[k]), // [RL10]
            .o_clk     (clk_out[k])
        );
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            oe_reg <= 3'h0;
        else
            oe_reg <= oe_next;
    end

    // a PLL marked for suspend feeding an output not marked for suspend is flagged
    always_comb
    begin
        conflict = 1'b0;
        for (int k = 0; k < 3; k++)
            if (cfg_reg.sel[k] != 2'h0 && cfg_reg.pll_susp[cfg_reg.sel[k] - 2'h1]
                && !cfg_reg.out_susp[k])
                conflict = 1'b1; // [RL8]
    end

    assign o_clock_output_a    = clk_out[0];
    assign o_clock_output_b    = clk_out[1];
    assign o_clock_output_c    = clk_out[2];
    assign o_clock_output_a_oe = oe_reg[0];
    assign o_clock_output_b_oe = oe_reg[1];
    assign o_clock_output_c_oe = oe_reg[2];

    // ------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------
    assign status_word = {22'h000000, loaded_reg, oe_reg, shutdown, conflict,
                          pin_s2_reg, pll_locked};
    assign rd_value =
        (i_addr == ADDR_CTRL)   ? {30'h00000000, cfg_reg.gp_mode} :
        (i_addr == ADDR_ROUTE)  ? {23'h000000, cfg_reg.inv, cfg_reg.sel} :
        (i_addr == ADDR_DIV_A)  ? {17'h00000, cfg_reg.div_a1, 1'b0, cfg_reg.div_a0} :
        (i_addr == ADDR_DIV_B)  ? {17'h00000, cfg_reg.div_b1, 1'b0, cfg_reg.div_b0} :
        (i_addr == ADDR_DIV_C)  ? {25'h0000000, cfg_reg.div_c} :
        (i_addr == ADDR_SUSP)   ? {26'h0000000, cfg_reg.pll_susp, cfg_reg.out_susp} :
        (i_addr == ADDR_PLL0)   ? {13'h0000, cfg_reg.p[0], cfg_reg.q[0]} :
        (i_addr == ADDR_PLL0 + 4'h1) ? {13'h0000, cfg_reg.p[1], cfg_reg.q[1]} :
        (i_addr == ADDR_PLL0 + 4'h2) ? {13'h0000, cfg_reg.p[2], cfg_reg.q[2]} :
        (i_addr == ADDR_STATUS) ? status_word : 32'h00000000;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= 32'h00000000;
        else
            o_rdata <= i_rd ? rd_value : 32'h00000000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    property p_oe_mode;
        (cfg_reg.gp_mode == GP_OE && pin_low) |=> oe_reg == 3'h0;
    endproperty
    a_oe_mode: assert property (p_oe_mode) // [RL4]
        else $error("enable low did not tristate outputs");

    property p_shutdown;
        shutdown |=> (oe_reg == 3'h0) ##0 (pll_tick == 3'h0 || !$past(shutdown));
    endproperty
    a_shutdown: assert property (p_shutdown) // [RL5]
        else $error("shutdown left an output or PLL running");

    property p_relock;
        $fell(shutdown) |-> (pll_tick == 3'h0)[*4];
    endproperty
    a_relock: assert property (p_relock) // [RL6]
        else $error("PLL produced output before relocking");

    property p_suspend_out;
        suspend_low |=> (oe_reg & $past(cfg_reg.out_susp)) == 3'h0;
    endproperty
    a_suspend_out: assert property (p_suspend_out) // [RL7]
        else $error("suspended output still driven");

    property p_suspend_pll;
        suspend_low |=> ((pll_tick | pll_locked) & $past(cfg_reg.pll_susp)) == 3'h0;
    endproperty
    a_suspend_pll: assert property (p_suspend_pll) // [RL9]
        else $error("suspended PLL still active");

    property p_route_a;
        ($changed(o_clock_output_a) && $past(cfg_reg.inv[0]) == $past(cfg_reg.inv[0], 2)
            && !$past(shutdown))
            |-> $past(out_tick[0]);
    endproperty
    a_route_a: assert property (p_route_a) // [RL1]
        else $error("output A moved without a tick from its source");

    property p_c_ignores_select;
        ($changed(pin_s2_reg) && $stable(cfg_reg.div_c)) |-> $stable(div_val[2]);
    endproperty
    a_c_ignores_select: assert property (p_c_ignores_select) // [RL3]
        else $error("output C divider followed the select input");

    property p_select_only_in_fs;
        (cfg_reg.gp_mode != GP_FS) |-> div_val[0] == cfg_reg.div_a0 && !fs_level;
    endproperty
    a_select_only_in_fs: assert property (p_select_only_in_fs) // [RL11]
        else $error("select acted outside its mode");

    property p_fs_picks_a1;
        (cfg_reg.gp_mode == GP_FS && pin_s2_reg) |-> div_val[0] == cfg_reg.div_a1;
    endproperty
    a_fs_picks_a1: assert property (p_fs_picks_a1) // [RL2]
        else $error("high select did not pick second A setting");

    property p_loaded_first;
        !$past(loaded_reg) |-> oe_reg == 3'h0;
    endproperty
    a_loaded_first: assert property (p_loaded_first) // [RL14]
        else $error("outputs enabled before settings applied");

    c_shutdown_exit: cover property ($fell(shutdown));
    c_fs_toggle:     cover property (cfg_reg.gp_mode == GP_FS && $changed(pin_s2_reg));
    c_pll_lock:      cover property ($rose(pll_locked[0]));
    c_conflict:      cover property (conflict);
endmodule
`default_nettype wire

// [cog_pkg.sv]
`default_nettype none
package cog_pkg;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int unsigned      DATA_W        = 32;
    localparam int unsigned      ADDR_W        = 4;
    localparam int unsigned      DIV_W         = 7;
    localparam int unsigned      Q_W           = 8;
    localparam int unsigned      P_W           = 11;
    localparam int unsigned      ACC_W         = 20;
    localparam int unsigned      ACC_FRAC      = 8;
    localparam int unsigned      LOCK_W        = 20;
    localparam longint unsigned  CLK_PERIOD_PS = 4000;
    localparam longint unsigned  LOCK_TIME_US  = 3000;
    localparam int unsigned      LOCK_CYCLES   = int'((LOCK_TIME_US * 64'd1000000) / CLK_PERIOD_PS);

    // ------------------------------------------------------------
    // register indices and field positions
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_ROUTE  = 4'h1;
    localparam logic [3:0] ADDR_DIV_A  = 4'h2;
    localparam logic [3:0] ADDR_DIV_B  = 4'h3;
    localparam logic [3:0] ADDR_DIV_C  = 4'h4;
    localparam logic [3:0] ADDR_SUSP   = 4'h5;
    localparam logic [3:0] ADDR_PLL0   = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    localparam int unsigned ROUTE_INV_LSB = 6;
    localparam int unsigned DIV_SET1_LSB  = 8;
    localparam int unsigned SUSP_PLL_LSB  = 3;
    localparam int unsigned PLL_P_LSB     = 8;
    localparam int unsigned ST_PIN_BIT    = 3;
    localparam int unsigned ST_CONF_BIT   = 4;
    localparam int unsigned ST_SHDN_BIT   = 5;
    localparam int unsigned ST_OE_LSB     = 6;
    localparam int unsigned ST_LOAD_BIT   = 9;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {GP_FS, GP_SUSPEND, GP_OE, GP_SHUTDOWN} cog_gpmode_e;

    typedef struct packed {
        cog_gpmode_e              gp_mode;
        logic [2:0][1:0]          sel;
        logic [2:0]               inv;
        logic [DIV_W-1:0]         div_a0;
        logic [DIV_W-1:0]         div_a1;
        logic [DIV_W-1:0]         div_b0;
        logic [DIV_W-1:0]         div_b1;
        logic [DIV_W-1:0]         div_c;
        logic [2:0]               out_susp;
        logic [2:0]               pll_susp;
        logic [2:0][Q_W-1:0]      q;
        logic [2:0][P_W-1:0]      p;
    } cog_cfg_s;

    // power-up image of the nonvolatile settings
    localparam cog_cfg_s CFG_RESET = '{
        gp_mode  : GP_OE,
        sel      : 6'h39,
        inv      : 3'h0,
        div_a0   : 7'h02,
        div_a1   : 7'h04,
        div_b0   : 7'h02,
        div_b1   : 7'h04,
        div_c    : 7'h02,
        out_susp : 3'h0,
        pll_susp : 3'h0,
        q        : 24'h010101,
        p        : 33'h008010040
    };
endpackage
`default_nettype wire

// [cog_post_div.sv]
`timescale 1ns/1ps
`default_nettype none
module cog_post_div
    import cog_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    input  wire logic             i_clear,
    input  wire logic             i_tick,
    input  wire logic [DIV_W-1:0] i_div,
    input  wire logic             i_inv,
    output var  logic             o_clk
);
    logic [DIV_W-1:0] cnt_reg;
    logic             phase_reg;
    logic [DIV_W-1:0] div_eff;
    logic             expire;
    logic             phase_next;

    assign div_eff    = (i_div == 7'h00) ? 7'h01 : i_div;
    assign expire     = i_tick & (cnt_reg == 7'h00);
    assign phase_next = expire ? ~phase_reg : phase_reg;

    // ------------------------------------------------------------
    // new value is taken only when the running half period ends
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_reg   <= 7'h00;
            phase_reg <= 1'b0;
            o_clk     <= 1'b0;
        end
        else if (i_clear)
        begin
            cnt_reg   <= 7'h00;
            phase_reg <= 1'b0;
            o_clk     <= i_inv;
        end
        else
        begin
            if (expire)
                cnt_reg <= div_eff - 7'h01; // [RL12]
            else if (i_tick)
                cnt_reg <= cnt_reg - 7'h01;
            phase_reg <= phase_next;
            o_clk     <= phase_next ^ i_inv; // [RL10]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_toggle_on_expiry;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ($changed(phase_reg) && !$past(i_clear)) |-> $past(i_tick) && $past(cnt_reg) == 7'h00;
    endproperty
    a_toggle_on_expiry: assert property (p_toggle_on_expiry) // [RL12]
        else $error("post divider toggled before its count expired");
endmodule
`default_nettype wire

// [cog_clock_load.sv]
`timescale 1ns/1ps
`default_nettype none
module cog_clock_load
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    input  wire logic       i_clear,
    input  wire logic       i_line,
    input  wire logic       i_oe,
    output var  logic       o_pin,
    output var  logic [7:0] o_period,
    output var  logic [7:0] o_min_run
);
    // ------------------------------------------------------------
    // board load: resolves the pin and measures what it receives
    // ------------------------------------------------------------
    logic       float_reg;
    logic       last_reg;
    logic       seen_reg;
    logic [7:0] run_reg;
    logic [7:0] per_reg;
    logic       chg;
    logic       rise;

    // an undriven pin shows a changing pattern, never the last level
    assign o_pin = i_oe ? i_line : float_reg;
    assign chg   = o_pin != last_reg;
    assign rise  = o_pin && !last_reg;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            float_reg <= 1'b0;
            last_reg  <= 1'b0;
            seen_reg  <= 1'b0;
            run_reg   <= 8'h00;
            per_reg   <= 8'h00;
            o_period  <= 8'h00;
            o_min_run <= 8'hFF;
        end
        else
        begin
            float_reg <= ~float_reg;
            last_reg  <= o_pin;
            if (i_clear)
            begin
                seen_reg  <= 1'b0;
                o_period  <= 8'h00;
                o_min_run <= 8'hFF;
            end
            else if (i_oe)
            begin
                run_reg <= chg ? 8'h01 : run_reg + 8'h01;
                per_reg <= rise ? 8'h01 : per_reg + 8'h01;
                seen_reg <= seen_reg | chg;
                if (chg && seen_reg && run_reg < o_min_run)
                    o_min_run <= run_reg;
                if (rise && seen_reg)
                    o_period <= per_reg;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_cog_clock_out.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_cog_clock_out
    import cog_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              fsin;
    logic              clr;
    logic              ca, cb, cc, cao, cbo, cco;
    logic [2:0]        line;
    logic [2:0]        oe;
    logic [2:0]        pin;
    logic [7:0]        per [3];
    logic [7:0]        mrun [3];
    logic              x0;
    int                n_errors;
    int                n_tests;
    int                tper [4] = '{1, 1, 2, 4};
    logic [7:0]        pq [3] = '{8'h01, 8'h01, 8'h02};
    logic [10:0]       pp [3] = '{11'h100, 11'h080, 11'h080};

    assign line = {cc, cb, ca};
    assign oe   = {cco, cbo, cao};

    cog_clock_out #(.LOCK_CYC(16)) i_dut (
        .i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_frequency_select_input(fsin),
        .o_clock_output_a(ca), .o_clock_output_a_oe(cao),
        .o_clock_output_b(cb), .o_clock_output_b_oe(cbo),
        .o_clock_output_c(cc), .o_clock_output_c_oe(cco));

    for (genvar g = 0; g < 3; g++)
    begin : g_load
        cog_clock_load i_load (.i_clk_sys(clk), .i_arst_n(rst_n), .i_clear(clr),
            .i_line(line[g]), .i_oe(oe[g]), .o_pin(pin[g]), .o_period(per[g]),
            .o_min_run(mrun[g]));
    end

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata & m);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pin_set(input logic v);
        @(posedge clk);
        fsin <= v;
    endtask

    task automatic per_chk(input int p0, input int p1, input int p2);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wait_n(60);
        chk("period a", 32'(p0), {24'h0, per[0]});
        chk("period b", 32'(p1), {24'h0, per[1]});
        chk("period c", 32'(p2), {24'h0, per[2]});
    endtask

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 0; rst_n = 0; addr = '0; wdata = '0; wr = 0; rd = 0; fsin = 1; clr = 0;
        n_errors = 0; n_tests = 0;
        #5;
        chk("oe in reset", 32'h0, {29'h0, oe});
        chk("rdata in reset", 32'h0, rdata);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wait_n(2);
        rd_chk("mode", ADDR_CTRL, 32'h3, {30'h0, CFG_RESET.gp_mode});
        rd_chk("route", ADDR_ROUTE, 32'h1FF, {23'h0, CFG_RESET.inv, CFG_RESET.sel});
        rd_chk("div a", ADDR_DIV_A, 32'h7F7F,
               {17'h0, CFG_RESET.div_a1, 1'b0, CFG_RESET.div_a0});
        rd_chk("div c", ADDR_DIV_C, 32'h7F, {25'h0, CFG_RESET.div_c});
        rd_chk("loaded", ADDR_STATUS, 32'h3C0, 32'h3C0);
        wr_reg(4'hA, 32'hFFFFFFFF);
        rd_chk("unmapped", 4'hA, 32'hFFFFFFFF, 32'h0);
        wr_reg(ADDR_STATUS, 32'h0);
        rd_chk("status ro", ADDR_STATUS, 32'h200, 32'h200);
        for (int k = 0; k < 3; k++)
            wr_reg(ADDR_PLL0 + 4'(k), {13'h0, pp[k], pq[k]});
        wr_reg(ADDR_DIV_A, 32'h0101);
        wr_reg(ADDR_DIV_B, 32'h0101);
        wr_reg(ADDR_DIV_C, 32'h01);
        wait_n(40);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(ADDR_ROUTE, {26'h0, 2'(s + 2), 2'(s + 1), 2'(s)});
            per_chk(2 * tper[s], 2 * tper[(s + 1) % 4], 2 * tper[(s + 2) % 4]);
        end
        wr_reg(ADDR_CTRL, 32'h0);
        wr_reg(ADDR_ROUTE, 32'h0);
        wr_reg(ADDR_DIV_A, 32'h0302);
        wr_reg(ADDR_DIV_B, 32'h0504);
        wr_reg(ADDR_DIV_C, 32'h06);
        pin_set(1'b0);
        per_chk(4, 8, 12);
        pin_set(1'b1);
        per_chk(6, 10, 12);
        chk("oe select mode", 32'h7, {29'h0, oe});
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (6)
        begin
            pin_set(~fsin);
            wait_n(7);
        end
        chk("min run a", 32'h2, {24'h0, mrun[0]});
        chk("min run b", 32'h4, {24'h0, mrun[1]});
        wr_reg(ADDR_DIV_A, 32'h0101);
        wr_reg(ADDR_DIV_B, 32'h0101);
        wait_n(8);
        x0 = ca ^ cb;
        wait_n(3);
        chk("phase", {31'h0, x0}, {31'h0, ca ^ cb});
        wr_reg(ADDR_ROUTE, 32'h040);
        wait_n(8);
        chk("inverted phase", {31'h0, ~x0}, {31'h0, ca ^ cb});
        wr_reg(ADDR_CTRL, 32'h2);
        pin_set(1'b0);
        wait_n(4);
        chk("oe low", 32'h0, {29'h0, oe});
        rd_chk("status oe", ADDR_STATUS, 32'h1C0, 32'h0);
        pin_set(1'b1);
        wait_n(4);
        chk("oe high", 32'h7, {29'h0, oe});
        wr_reg(ADDR_ROUTE, 32'h33);
        wr_reg(ADDR_SUSP, 32'h25);
        wr_reg(ADDR_CTRL, 32'h1);
        pin_set(1'b0);
        wait_n(4);
        chk("oe suspend", 32'h2, {29'h0, oe});
        rd_chk("lock suspend", ADDR_STATUS, 32'h17, 32'h03);
        pin_set(1'b1);
        wait_n(40);
        chk("oe resume", 32'h7, {29'h0, oe});
        rd_chk("lock resume", ADDR_STATUS, 32'h7, 32'h7);
        wr_reg(ADDR_SUSP, 32'h20);
        pin_set(1'b0);
        wait_n(4);
        rd_chk("conflict", ADDR_STATUS, 32'h10, 32'h10);
        pin_set(1'b1);
        wr_reg(ADDR_SUSP, 32'h0);
        wr_reg(ADDR_CTRL, 32'h3);
        pin_set(1'b0);
        wait_n(4);
        chk("oe shutdown", 32'h0, {29'h0, oe});
        rd_chk("shutdown", ADDR_STATUS, 32'h27, 32'h20);
        pin_set(1'b1);
        wait_n(4);
        rd_chk("relock pending", ADDR_STATUS, 32'h7, 32'h0);
        wait_n(40);
        rd_chk("relocked", ADDR_STATUS, 32'h7, 32'h7);
        wr_reg(ADDR_DIV_C, 32'h01);
        per_chk(8, 2, 8);
        final_report();
    end
endmodule
`default_nettype wire
